// ==== hw/dals_map.svh ====
// register map, field layout, reset values and timing counts of the lock sequencer
// Functional notes
// (RULE1) dco step adjusts feedback divider modulator
// (RULE2) dco change reaches outputs and cascaded domains
// (RULE3) software keeps loop bandwidth within limits
// (RULE4) analog loops lock free-run before digital loops
// (RULE5) independent loops acquire on valid reference
// (RULE6) phase error word steers analog divider
// (RULE7) independent loops never disturb each other
// (RULE8) cascaded mode: loop three leads acquisition
// (RULE9) downstream loops ride loop three offset
// (RULE10) all enabled loops locked means synchronized
// (RULE11) vco3 held centered while downstream lock
// (RULE12) reference qualified before acquisition starts
// (RULE13) first error cancelled, later words filtered
// (RULE14) software recalibrates downstream by enable toggle
// (RULE15) disabled downstream loops track vco3 domain
// (RULE16) analog-only mode ignores digital loops entirely
// (RULE17) analog loops start in priority order
// (RULE18) denominator select picks 24 or 40 bit
// (RULE19) software never routes vco to both references
`ifndef DALS_MAP_SVH
`define DALS_MAP_SVH
`define DALS_OFF_CTRL 12'h000
`define DALS_OFF_PRIO 12'h004
`define DALS_OFF_QUAL 12'h008
`define DALS_OFF_GAIN 12'h00C
`define DALS_OFF_FSTEP 12'h010
`define DALS_OFF_DCO 12'h014
`define DALS_OFF_STAT 12'h018
`define DALS_OFF_DCO3 12'h01C
`define DALS_CTRL_W 13
`define DALS_PRIO_W 6
`define DALS_DCO_DEC_LSB 3
`define DALS_CTRL_RST 13'h001C
`define DALS_PRIO_RST 6'h24
`define DALS_QUAL_RST 16'h0100
`define DALS_GAIN_RST 4'h4
`define DALS_FSTEP_RST 24'h000001
`define DALS_LOCK_N 4'h8
`define DALS_LOCK_TOL 16'h0010
`define DALS_LVL_LAST 2'h3
`endif

// ==== hw/dals_pkg.sv ====
// types shared by the lock sequencer modules
package dals_pkg;
  typedef enum logic [1:0] {MD_INDEP = 2'h0, MD_CASC_DPLL = 2'h1, MD_CASC_APLL = 2'h2, MD_APLL_ONLY = 2'h3} dals_mode_t;
  typedef enum logic [5:0] {SQ_INIT = 6'h01, SQ_APLL = 6'h02, SQ_WAIT = 6'h04, SQ_SRC = 6'h08, SQ_SRCW = 6'h10,
    SQ_RUN = 6'h20} dals_seq_t;
  typedef enum logic [3:0] {CH_IDLE = 4'h1, CH_QUAL = 4'h2, CH_CANCEL = 4'h4, CH_TRACK = 4'h8} dals_ch_t;
  typedef struct packed {
    logic [2:0] den_sel;
    logic [1:0] casc;
    logic [2:0] dpll_en;
    logic [2:0] apll_en;
    dals_mode_t mode;
  } dals_ctrl_t;
  typedef struct packed {
    logic valid;
    logic signed [15:0] err;
  } dals_tdc_t;
  typedef struct packed {
    logic [31:0] steer;
    logic [15:0] cancel;
    logic cancel_stb;
    logic locked;
    logic active;
  } dals_chout_t;
  typedef struct packed {
    dals_ch_t st;
    logic [15:0] qcnt;
    logic [31:0] integ;
    logic [3:0] lcnt;
    logic [15:0] cancel;
    logic cstb;
  } dals_ch_st_t;
  typedef struct packed {
    dals_seq_t seq;
    logic [1:0] lvl;
    logic [1:0] ch;
    logic [2:0] apll_on;
    dals_ctrl_t ctrl;
    logic [5:0] prio;
    logic [15:0] qual;
    logic [3:0] gain;
    logic [23:0] fstep;
    logic [2:0] dco_inc;
    logic [2:0] dco_dec;
    logic [31:0] prdata;
    logic [2:0][31:0] steer;
  } dals_top_st_t;
endpackage : dals_pkg

// ==== hw/dals_dco.sv ====
// frequency step accumulator for one feedback divider modulator
`timescale 1ns/1ps
`include "dals_map.svh"
module dals_dco
  import dals_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // step requests
  input wire logic inc,
  input wire logic dec,
  input wire logic [23:0] step,
  // accumulated offset
  output logic [31:0] offset
);
  logic [31:0] s_q;
  logic [31:0] s_d;

  always_comb
  begin
    s_d = s_q;
    // (RULE1) add or subtract step
    if (inc && !dec)
    begin
      s_d = s_q + {8'h00, step};
    end
    else if (dec && !inc)
    begin
      s_d = s_q - {8'h00, step};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= 32'h00000000;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign offset = s_q;

  property p_dco_step;
    @(posedge pclk) disable iff (!presetn)
    (inc && !dec) |=> (offset == $past(offset) + {8'h00, $past(step)}) && $changed(offset) || ($past(step) == 24'h0);
  endproperty
  a_dco_step: assert property (p_dco_step) else $error("dco increment not applied"); // RULE1
endmodule : dals_dco

// ==== hw/dals_chan.sv ====
// one digital loop: reference qualification, phase cancel, filtered steering
`timescale 1ns/1ps
`include "dals_map.svh"
module dals_chan
  import dals_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic ref_ok,
  input wire logic [15:0] qual_cnt,
  input wire logic [3:0] gain,
  input wire logic apll_locked,
  // phase detector
  input wire dals_tdc_t tdc,
  // loop results
  output dals_chout_t chout
);
  dals_ch_st_t s_q;
  dals_ch_st_t s_d;
  logic signed [31:0] e32;
  logic [15:0] mag;

  always_comb
  begin
    s_d = s_q;
    s_d.cstb = 1'b0;
    e32 = 32'(tdc.err);
    mag = tdc.err[15] ? 16'(-tdc.err) : tdc.err;
    case (s_q.st)
      CH_IDLE:
      begin
        // (RULE5) start once reference valid
        if (run && ref_ok)
        begin
          s_d.st = CH_QUAL;
          s_d.qcnt = 16'h0000;
        end
        if (!run)
        begin
          s_d.integ = 32'h00000000;
        end
      end
      CH_QUAL:
      begin
        // (RULE12) reference must outlast qualification
        if (!run || !ref_ok)
        begin
          s_d.st = CH_IDLE;
        end
        else if (s_q.qcnt >= qual_cnt)
        begin
          s_d.st = CH_CANCEL;
        end
        else
        begin
          s_d.qcnt = s_q.qcnt + 16'h0001;
        end
      end
      CH_CANCEL:
      begin
        // (RULE13) first error cancelled unfiltered
        if (!run || !ref_ok)
        begin
          s_d.st = CH_IDLE;
        end
        else if (tdc.valid)
        begin
          s_d.cancel = tdc.err;
          s_d.cstb = 1'b1;
          s_d.integ = 32'h00000000;
          s_d.lcnt = 4'h0;
          s_d.st = CH_TRACK;
        end
      end
      CH_TRACK:
      begin
        // loss of reference keeps the integrator as holdover
        if (!run || !ref_ok)
        begin
          s_d.st = CH_IDLE;
        end
        else if (tdc.valid)
        begin
          // (RULE6) filtered word steers divider
          s_d.integ = 32'($signed(s_q.integ) + (e32 >>> gain));
          if (mag > `DALS_LOCK_TOL)
          begin
            s_d.lcnt = 4'h0;
          end
          else if (s_q.lcnt != `DALS_LOCK_N)
          begin
            s_d.lcnt = s_q.lcnt + 4'h1;
          end
        end
      end
      default:
      begin
        s_d.st = CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '{st: CH_IDLE, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign chout = '{steer: s_q.integ, cancel: s_q.cancel, cancel_stb: s_q.cstb,
    locked: (s_q.st == CH_TRACK) && (s_q.lcnt == `DALS_LOCK_N) && apll_locked, active: s_q.st != CH_IDLE};

  sequence s_cancel_hit;
    (s_q.st == CH_CANCEL) && run && ref_ok && tdc.valid;
  endsequence
  property p_cancel;
    @(posedge pclk) disable iff (!presetn)
    s_cancel_hit |=> chout.cancel_stb && (s_q.st == CH_TRACK) && (chout.steer == 32'h0) && (chout.cancel == $past(tdc.err));
  endproperty
  a_cancel: assert property (p_cancel) else $error("first phase error not cancelled"); // RULE13
  property p_qual;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == CH_QUAL) && (s_q.qcnt < qual_cnt) |=> s_q.st != CH_CANCEL;
  endproperty
  a_qual: assert property (p_qual) else $error("acquisition before qualification"); // RULE12
  property p_filter;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == CH_TRACK) && run && ref_ok && tdc.valid |=>
      $signed(chout.steer) == $signed($past(chout.steer)) + ($past(e32) >>> $past(gain));
  endproperty
  a_filter: assert property (p_filter) else $error("filtered steering wrong"); // RULE6
  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == CH_IDLE) && run && ref_ok |=> s_q.st == CH_QUAL ##1 (s_q.st != CH_TRACK);
  endproperty
  a_start: assert property (p_start) else $error("acquisition did not start"); // RULE5
endmodule : dals_chan

// ==== hw/dals_seq.sv ====
// lock sequencer top: apb registers, analog start order, three digital loops
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "dals_map.svh"
module dals_seq
  import dals_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // loop status from the analog side
  input wire logic [2:0] ref_valid,
  input wire logic vco3_ref_ok,
  input wire logic [2:0] apll_lock,
  input wire dals_tdc_t [2:0] tdc,
  // analog loop control
  output logic [2:0] analog_loop_enable,
  output logic [1:0] apll_casc_sel,
  output logic vco3_hold_center,
  output logic [2:0] denominator_select,
  // digital loop results
  output logic [2:0] dpll_run,
  output logic [2:0] dpll_locked,
  output logic [2:0][31:0] fb_sdm_adj,
  output logic [2:0][31:0] n_sdm_steer,
  output logic [2:0] phase_cancel_stb,
  output logic [2:0][15:0] phase_cancel_word,
  output logic all_synced
);
  dals_top_st_t s_q;
  dals_top_st_t s_d;
  dals_chout_t [2:0] chout;
  logic [2:0][31:0] dco_off;
  logic [2:0] run_w;
  logic [2:0] ref_ok_w;
  logic [2:0] dpll_want;
  logic hit;
  logic acc;
  logic wen;
  logic src_defer;
  logic adv_done;
  logic [1:0] adv_ch;
  logic [1:0] adv_lvl;
  logic [1:0] prio_ch;
  logic [31:0] rmux;
  logic [31:0] wval;
  logic [31:0] own;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // apb decode; every access completes in its first access cycle
  always_comb
  begin
    case (paddr)
      `DALS_OFF_CTRL: rmux = {19'h0, s_q.ctrl};
      `DALS_OFF_PRIO: rmux = {26'h0, s_q.prio};
      `DALS_OFF_QUAL: rmux = {16'h0, s_q.qual};
      `DALS_OFF_GAIN: rmux = {28'h0, s_q.gain};
      `DALS_OFF_FSTEP: rmux = {8'h0, s_q.fstep};
      `DALS_OFF_DCO: rmux = 32'h00000000;
      `DALS_OFF_STAT: rmux = {18'h0, vco3_hold_center, all_synced, apll_lock, dpll_locked, s_q.seq};
      `DALS_OFF_DCO3: rmux = dco_off[2];
      default: rmux = 32'h00000000;
    endcase
    hit = (paddr[1:0] == 2'h0) && (paddr <= `DALS_OFF_DCO3);
  end

  assign acc = psel && penable;
  assign wen = acc && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = s_q.prdata;

  // cascaded downstream loops defer the source loop start
  assign src_defer = s_q.ctrl.apll_en[2] && |(s_q.ctrl.casc & s_q.ctrl.apll_en[1:0]);

  always_comb
  begin
    adv_ch = s_q.ch + 2'h1;
    adv_lvl = s_q.lvl;
    adv_done = 1'b0;
    prio_ch = s_q.prio[s_q.ch*2 +: 2];
    if (s_q.ch == 2'h2)
    begin
      adv_ch = 2'h0;
      adv_lvl = s_q.lvl + 2'h1;
      adv_done = s_q.lvl == `DALS_LVL_LAST;
    end
  end

  always_comb
  begin
    s_d = s_q;
    wval = merge(32'h0, pwdata, pstrb);
    s_d.dco_inc = 3'h0;
    s_d.dco_dec = 3'h0;
    if (psel && !penable)
    begin
      s_d.prdata = rmux;
    end
    if (wen)
    begin
      case (paddr)
        `DALS_OFF_CTRL: s_d.ctrl = dals_ctrl_t'(13'(merge({19'h0, s_q.ctrl}, pwdata, pstrb)));
        `DALS_OFF_PRIO: s_d.prio = 6'(merge({26'h0, s_q.prio}, pwdata, pstrb));
        `DALS_OFF_QUAL: s_d.qual = 16'(merge({16'h0, s_q.qual}, pwdata, pstrb));
        `DALS_OFF_GAIN: s_d.gain = 4'(merge({28'h0, s_q.gain}, pwdata, pstrb));
        `DALS_OFF_FSTEP: s_d.fstep = 24'(merge({8'h0, s_q.fstep}, pwdata, pstrb));
        `DALS_OFF_DCO:
        begin
          s_d.dco_inc = wval[2:0];
          s_d.dco_dec = wval[`DALS_DCO_DEC_LSB +: 3];
        end
        default:
        begin
          s_d.prdata = s_q.prdata;
        end
      endcase
    end
    case (s_q.seq)
      SQ_INIT:
      begin
        s_d.apll_on = 3'h0;
        s_d.lvl = 2'h0;
        s_d.ch = 2'h0;
        s_d.seq = SQ_APLL;
      end
      SQ_APLL:
      begin
        // (RULE17) one loop at a time, in priority level order
        if (s_q.ctrl.apll_en[s_q.ch] && (prio_ch == s_q.lvl) && !((s_q.ch == 2'h2) && src_defer))
        begin
          s_d.apll_on[s_q.ch] = 1'b1;
          s_d.seq = SQ_WAIT;
        end
        else
        begin
          s_d.ch = adv_ch;
          s_d.lvl = adv_lvl;
          s_d.seq = adv_done ? SQ_SRC : SQ_APLL;
        end
      end
      SQ_WAIT:
      begin
        // (RULE17) next loop only after lock or enable cleared
        if (apll_lock[s_q.ch] || !s_q.ctrl.apll_en[s_q.ch])
        begin
          s_d.ch = adv_ch;
          s_d.lvl = adv_lvl;
          s_d.seq = adv_done ? SQ_SRC : SQ_APLL;
        end
      end
      SQ_SRC:
      begin
        // (RULE11) source loop locks after downstream
        if (src_defer)
        begin
          s_d.apll_on[2] = 1'b1;
          s_d.seq = SQ_SRCW;
        end
        else
        begin
          s_d.seq = SQ_RUN;
        end
      end
      SQ_SRCW:
      begin
        if (apll_lock[2])
        begin
          s_d.seq = SQ_RUN;
        end
      end
      SQ_RUN:
      begin
        s_d.seq = SQ_RUN;
      end
      default:
      begin
        s_d.seq = SQ_INIT;
      end
    endcase
    // (RULE15) disabled downstream loops follow vco3
    for (int i = 2; i >= 0; i--)
    begin
      // (RULE16) analog-only steering is dco alone
      own = (s_q.ctrl.mode == MD_APLL_ONLY) ? dco_off[i] : chout[i].steer;
      if ((i < 2) && s_q.ctrl.casc[i] && !run_w[i])
      begin
        // (RULE2) upstream adjustment carried downstream
        own = own + s_d.steer[2];
      end
      s_d.steer[i] = own;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '{seq: SQ_INIT, ctrl: dals_ctrl_t'(`DALS_CTRL_RST), prio: `DALS_PRIO_RST, qual: `DALS_QUAL_RST,
        gain: `DALS_GAIN_RST, fstep: `DALS_FSTEP_RST, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      // (RULE16) digital loops unused in analog-only mode
      dpll_want[i] = s_q.ctrl.dpll_en[i] && (s_q.ctrl.mode != MD_APLL_ONLY);
      // (RULE4) digital loops wait for free-run
      run_w[i] = dpll_want[i] && (s_q.seq == SQ_RUN) && analog_loop_enable[i];
      // (RULE8) loop three keeps its own reference
      // (RULE9) downstream reference is vco3 domain
      ref_ok_w[i] = ((s_q.ctrl.mode == MD_CASC_DPLL) && (i < 2)) ? vco3_ref_ok : ref_valid[i];
    end
  end

  // (RULE7) each loop has its own instance
  for (genvar g = 0; g < 3; g++)
  begin : g_loop
    dals_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .run(run_w[g]),
      .ref_ok(ref_ok_w[g]),
      .qual_cnt(s_q.qual),
      .gain(s_q.gain),
      .apll_locked(apll_lock[g]),
      .tdc(tdc[g]),
      .chout(chout[g])
    );
    dals_dco u_dco (
      .pclk(pclk),
      .presetn(presetn),
      .inc(s_q.dco_inc[g]),
      .dec(s_q.dco_dec[g]),
      .step(s_q.fstep),
      .offset(dco_off[g])
    );
    assign dpll_locked[g] = chout[g].locked;
    assign phase_cancel_stb[g] = chout[g].cancel_stb;
    assign phase_cancel_word[g] = chout[g].cancel;
    // (RULE1) offset feeds feedback divider outside analog-only mode
    assign fb_sdm_adj[g] = (s_q.ctrl.mode == MD_APLL_ONLY) ? 32'h0 : dco_off[g];
  end

  // (RULE14) enable bit low drops the loop
  assign analog_loop_enable = s_q.apll_on & s_q.ctrl.apll_en;
  assign apll_casc_sel = s_q.ctrl.casc;
  // (RULE11) hold vco3 during downstream start
  assign vco3_hold_center = src_defer && ((s_q.seq == SQ_APLL) || (s_q.seq == SQ_WAIT) || (s_q.seq == SQ_INIT));
  // (RULE18) zero selects programmable denominator
  assign denominator_select = s_q.ctrl.den_sel;
  assign dpll_run = run_w;
  assign n_sdm_steer = s_q.steer;
  // (RULE10) everything enabled locked
  assign all_synced = (s_q.seq == SQ_RUN) && (&(~s_q.ctrl.apll_en | apll_lock)) && (&(~dpll_want | dpll_locked));

  property p_freerun_first;
    @(posedge pclk) disable iff (!presetn)
    |dpll_run |-> (s_q.seq == SQ_RUN) && ((dpll_run & ~analog_loop_enable) == 3'h0);
  endproperty
  a_freerun_first: assert property (p_freerun_first) else $error("digital loop ran before free-run"); // RULE4
  property p_apll_only;
    @(posedge pclk) disable iff (!presetn)
    (s_q.ctrl.mode == MD_APLL_ONLY) |-> (dpll_run == 3'h0) && (fb_sdm_adj == '0);
  endproperty
  a_apll_only: assert property (p_apll_only) else $error("digital loop active in analog-only mode"); // RULE16
  property p_one_start;
    @(posedge pclk) disable iff (!presetn)
    (s_q.seq != SQ_INIT) && $changed(s_q.apll_on) |-> $onehot(s_q.apll_on ^ $past(s_q.apll_on));
  endproperty
  a_one_start: assert property (p_one_start) else $error("two analog loops started together"); // RULE17
  property p_hold_release;
    @(posedge pclk) disable iff (!presetn)
    (s_q.seq == SQ_SRC) && src_defer |=> !vco3_hold_center && (s_q.seq == SQ_SRCW) && analog_loop_enable[2];
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("vco3 hold not released for lock"); // RULE11
  property p_synced;
    @(posedge pclk) disable iff (!presetn)
    all_synced |-> ((apll_lock & s_q.ctrl.apll_en) == s_q.ctrl.apll_en) && ((dpll_locked & dpll_want) == dpll_want);
  endproperty
  a_synced: assert property (p_synced) else $error("synced without all locks"); // RULE10
  property p_ctrl_wr;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && (paddr == `DALS_OFF_CTRL) && (pstrb == 4'hF) |=>
      s_q.ctrl == dals_ctrl_t'($past(pwdata[12:0]));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost"); // RULE18
endmodule : dals_seq

// ==== verif/dals_afe_model.sv ====
// behavioural analog side: apll lock after enable, periodic tdc words
`timescale 1ns/1ps
module dals_afe_model
  import dals_pkg::*;
#(
  parameter int LOCK_DLY = 6,
  parameter int TDC_PER = 4
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // from the sequencer
  input wire logic [2:0] analog_loop_enable,
  // bench-chosen phase errors
  input wire logic [2:0][15:0] err_in,
  // to the sequencer
  output logic [2:0] apll_lock,
  output dals_tdc_t [2:0] tdc
);
  int lcnt [3];
  int tcnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcnt <= 0;
      for (int i = 0; i < 3; i++)
      begin
        lcnt[i] <= 0;
        apll_lock[i] <= 1'b0;
      end
    end
    else
    begin
      tcnt <= (tcnt == TDC_PER - 1) ? 0 : tcnt + 1;
      for (int i = 0; i < 3; i++)
      begin
        // free-run lock to oscillator
        // lock is lost at once when the loop is disabled
        if (!analog_loop_enable[i])
        begin
          lcnt[i] <= 0;
          apll_lock[i] <= 1'b0;
        end
        else if (lcnt[i] < LOCK_DLY)
          lcnt[i] <= lcnt[i] + 1;
        else
          apll_lock[i] <= 1'b1;
      end
    end
  end
  // phase error word per compare
  // between words the error field shows the inverted error, never the last value
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      tdc[i].valid = presetn && (tcnt == 0) && analog_loop_enable[i];
      tdc[i].err = tdc[i].valid ? err_in[i] : ~err_in[i];
    end
  end
endmodule : dals_afe_model

// ==== verif/dals_seq_tb_top.sv ====
// self-checking bench of the lock sequencer
`timescale 1ns/1ps
`include "dals_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("mismatch %0t value differs", $time); end end
module dals_seq_tb_top;
  import dals_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] ref_valid = 3'h0;
  logic vco3_ref_ok = 1'b0;
  logic [2:0] apll_lock;
  dals_tdc_t [2:0] tdc;
  logic [2:0][15:0] err_in = '0;
  logic [2:0] analog_loop_enable;
  logic [1:0] apll_casc_sel;
  logic vco3_hold_center;
  logic [2:0] dpll_run;
  logic [2:0] dpll_locked;
  logic [2:0] phase_cancel_stb;
  logic [2:0][15:0] phase_cancel_word;
  logic [2:0][31:0] fb_sdm_adj;
  logic [2:0][31:0] n_sdm_steer;
  logic [2:0] denominator_select;
  logic all_synced;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic er;
  always #12.5 pclk = ~pclk;
  dals_seq dals_seq_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_valid(ref_valid), .vco3_ref_ok(vco3_ref_ok), .apll_lock(apll_lock), .tdc(tdc),
    .analog_loop_enable(analog_loop_enable), .apll_casc_sel(apll_casc_sel), .vco3_hold_center(vco3_hold_center),
    .denominator_select(denominator_select), .dpll_run(dpll_run), .dpll_locked(dpll_locked),
    .fb_sdm_adj(fb_sdm_adj), .n_sdm_steer(n_sdm_steer), .phase_cancel_stb(phase_cancel_stb),
    .phase_cancel_word(phase_cancel_word), .all_synced(all_synced));
  dals_afe_model dals_afe_model_i (.pclk(pclk), .presetn(presetn), .analog_loop_enable(analog_loop_enable),
    .err_in(err_in), .apll_lock(apll_lock), .tdc(tdc));
  task automatic end_of_test;
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // bounded wait for a condition given as a bit
  task automatic wait_bit(ref logic [2:0] v, input int b, input int lim);
    int n;
    n = 0;
    while (v[b] !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      n_errors++;
      end_of_test();
    end
  endtask : wait_bit
  task automatic sc_start_order;
    wait_bit(analog_loop_enable, 0, 200);
    `CHK(analog_loop_enable, 3'b001)
    wait_bit(analog_loop_enable, 1, 200);
    `CHK(apll_lock[0], 1'b1)
    `CHK(analog_loop_enable[2], 1'b0)
    wait_bit(analog_loop_enable, 2, 200);
    `CHK(apll_lock[1:0], 2'b11)
    `CHK(dpll_run, 3'b000)
  endtask : sc_start_order
  task automatic sc_regs;
    logic [11:0] ad [5];
    logic [31:0] ex [5];
    ad = '{`DALS_OFF_CTRL, `DALS_OFF_PRIO, `DALS_OFF_QUAL, `DALS_OFF_GAIN, `DALS_OFF_FSTEP};
    ex = '{32'h0000001C, 32'h00000024, 32'h00000100, 32'h00000004, 32'h00000001};
    for (int i = 0; i < 5; i++)
    begin
      apb(ad[i], 1'b0, 32'h0);
      `CHK(rd, ex[i])
      `CHK(er, 1'b0)
    end
    apb(12'h020, 1'b0, 32'h0);
    `CHK(er, 1'b1)
    apb(`DALS_OFF_STAT, 1'b0, 32'h0);
    `CHK(rd[5:0], 6'h20)
    `CHK(denominator_select, 3'b000)
  endtask : sc_regs
  task automatic sc_dco;
    logic [31:0] ops [4];
    logic [31:0] exp_v [4];
    ops = '{32'h04, 32'h04, 32'h20, 32'h24};
    exp_v = '{32'h5, 32'hA, 32'h5, 32'h5};
    apb(`DALS_OFF_FSTEP, 1'b1, 32'h5);
    for (int i = 0; i < 4; i++)
    begin
      apb(`DALS_OFF_DCO, 1'b1, ops[i]);
      repeat (3) @(posedge pclk);
      apb(`DALS_OFF_DCO3, 1'b0, 32'h0);
      `CHK(rd, exp_v[i])
      `CHK(fb_sdm_adj[2], exp_v[i])
    end
    `CHK(fb_sdm_adj[0], 32'h0)
  endtask : sc_dco
  task automatic sc_indep;
    int n;
    apb(`DALS_OFF_QUAL, 1'b1, 32'h4);
    apb(`DALS_OFF_GAIN, 1'b1, 32'h0);
    apb(`DALS_OFF_CTRL, 1'b1, 32'h7C);
    @(posedge pclk);
    err_in[0] <= 16'h0064;
    err_in[1] <= 16'hFFCE;
    ref_valid <= 3'b011;
    n = 0;
    #1;
    while (phase_cancel_stb[0] !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK(n >= 7 && n < 100, 1'b1)
    `CHK(phase_cancel_word[0], 16'h0064)
    @(posedge pclk);
    err_in[0] <= 16'h0003;
    err_in[1] <= 16'hFFFD;
    repeat (4) @(posedge pclk);
    `CHK(phase_cancel_word[1], 16'hFFCE)
    wait_bit(dpll_locked, 0, 300);
    wait_bit(dpll_locked, 1, 300);
    `CHK(all_synced, 1'b1)
    `CHK(n_sdm_steer[0] % 32'd3, 32'd0)
    `CHK(n_sdm_steer[0] != 32'h0, 1'b1)
    @(posedge pclk);
    ref_valid <= 3'b001;
    repeat (3) @(posedge pclk);
    `CHK(dpll_locked[1:0], 2'b01)
    `CHK(all_synced, 1'b0)
  endtask : sc_indep
  task automatic sc_apll_only;
    apb(`DALS_OFF_CTRL, 1'b1, 32'h14FF);
    repeat (3) @(posedge pclk);
    `CHK(dpll_run, 3'b000)
    `CHK(analog_loop_enable, 3'b111)
    `CHK(fb_sdm_adj[0], 32'h0)
    `CHK(denominator_select, 3'b101)
  endtask : sc_apll_only
  task automatic sc_casc;
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(analog_loop_enable, 3'b000)
    presetn <= 1'b1;
    // analog cascade only, digital references stay external
    apb(`DALS_OFF_CTRL, 1'b1, 32'h11C);
    @(posedge pclk);
    `CHK(apll_casc_sel, 2'b01)
    `CHK(vco3_hold_center, 1'b1)
    wait_bit(analog_loop_enable, 1, 200);
    `CHK(vco3_hold_center, 1'b1)
    wait_bit(analog_loop_enable, 2, 300);
    `CHK(apll_lock[1:0], 2'b11)
    `CHK(vco3_hold_center, 1'b0)
    wait_bit(apll_lock, 2, 100);
    // downstream enable cycled low then high
    apb(`DALS_OFF_CTRL, 1'b1, 32'h118);
    @(posedge pclk);
    `CHK(analog_loop_enable, 3'b110)
    apb(`DALS_OFF_CTRL, 1'b1, 32'h11C);
    wait_bit(apll_lock, 0, 100);
    `CHK(analog_loop_enable, 3'b111)
  endtask : sc_casc
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    sc_start_order();
    sc_regs();
    sc_dco();
    sc_indep();
    sc_apll_only();
    sc_casc();
    end_of_test();
  end
endmodule : dals_seq_tb_top
